// ### comparator_control.sv
// digital control around the on-chip analog comparator
`timescale 1ns/1ps
module comparator_control #(
    parameter int RATIO_W = cmp_pkg::RATIO_W
) (
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                srst,
    // software control writes
    input  wire logic                ctrl_we,
    input  wire logic [7:0]          ctrl_wdata,
    input  wire logic                irq_enable_we,
    input  wire logic                irq_enable_wdata,
    input  wire logic                irq_flag_clr,
    input  wire logic                global_irq_enable_instr,
    // power state and shared pin requests
    input  wire logic                sleep_mode,
    input  wire logic                idle_mode,
    input  wire logic                ext_reference_in,
    input  wire logic                adc_channel_three,
    input  wire logic                adc_channel_four,
    input  wire logic                adc_channel_five,
    input  wire logic                timer_ext_clock_in,
    input  wire logic                cmp_enable,
    // analog comparator raw output
    input  wire logic                cmp_raw,
    // analog ladder control
    output logic                     internal_ref_select_n,
    output logic [RATIO_W-1:0]       ref_ratio_code,
    output logic                     inv_from_ladder,
    // software visible state
    output logic [7:0]               cmp_control_reg,
    output logic                     cmp_result_bit,
    output logic                     cmp_irq_enable,
    output logic                     cmp_irq_flag,
    output logic                     irq_req,
    output logic                     wake_req,
    // pins
    output logic                     cmp_output_pin,
    output logic                     cmp_output_oe_n,
    output cmp_pkg::pin_fn_t         pin3_fn,
    output cmp_pkg::pin_fn_t         pin4_fn,
    output cmp_pkg::pin_fn_t         pin5_fn
);
    // *****************************************************
    // control fields
    // *****************************************************
    logic                 int_ref_n_q;
    logic [RATIO_W-1:0]   ratio_q;
    logic [1:0]           route_q;
    logic                 sync1_q;
    logic                 sync2_q;
    logic                 prev_q;
    logic                 change;
    cmp_pkg::pin_fn_t     fn3;
    cmp_pkg::pin_fn_t     fn4;
    cmp_pkg::pin_fn_t     fn5;
    logic                 rise;
    logic                 fall;
    logic                 irq_pending;
    logic                 irq_gate;
    logic                 low_power;
    logic                 pin4_cmp_req;
    logic                 pin3_cmp_req;
    logic                 pin5_cmp_req;
    logic                 route_to_pin;
    logic                 cmp_on_pin5;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            int_ref_n_q <= cmp_pkg::INT_REF_SEL_RESET;
        end else if (ctrl_we) begin
            int_ref_n_q <= ctrl_wdata[cmp_pkg::INT_REF_SEL_POS];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ratio_q <= RATIO_W'(cmp_pkg::RATIO_RESET);
        end else if (ctrl_we) begin
            ratio_q <= ctrl_wdata[cmp_pkg::RATIO_MSB_POS:cmp_pkg::RATIO_LSB_POS];
        end
    end

    // route select, bit two of a write is the read-only result
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            route_q <= cmp_pkg::ROUTE_RESET;
        end else if (ctrl_we) begin
            route_q <= ctrl_wdata[cmp_pkg::ROUTE_HI_POS:cmp_pkg::ROUTE_LO_POS];
        end
    end

    // *****************************************************
    // ladder control outputs
    // *****************************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            internal_ref_select_n <= cmp_pkg::INT_REF_SEL_RESET;
        end else begin
            internal_ref_select_n <= int_ref_n_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ref_ratio_code <= RATIO_W'(cmp_pkg::RATIO_RESET);
        end else begin
            ref_ratio_code <= ratio_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            inv_from_ladder <= 1'h0;
        end else begin
            inv_from_ladder <= ~int_ref_n_q;
        end
    end

    // *****************************************************
    // result sampling
    // *****************************************************
    // two stage synchroniser
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync1_q <= 1'h0;
            sync2_q <= 1'h0;
            prev_q  <= 1'h0;
        end else begin
            sync1_q <= cmp_raw & cmp_enable;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // either direction of the synchronised result counts as a change
    assign rise   = sync2_q & ~prev_q;
    assign fall   = ~sync2_q & prev_q;
    assign change = rise | fall;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cmp_result_bit <= 1'h0;
        end else begin
            cmp_result_bit <= sync2_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cmp_control_reg <= {cmp_pkg::INT_REF_SEL_RESET, cmp_pkg::RATIO_RESET, 1'h0, cmp_pkg::ROUTE_RESET};
        end else begin
            cmp_control_reg <= {int_ref_n_q, ratio_q, sync2_q, route_q};
        end
    end

    // *****************************************************
    // interrupt and wake-up
    // *****************************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cmp_irq_enable <= 1'h0;
        end else if (irq_enable_we) begin
            cmp_irq_enable <= irq_enable_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cmp_irq_flag <= 1'h0;
        end else if (change) begin
            cmp_irq_flag <= 1'h1;
        end else if (irq_flag_clr) begin
            cmp_irq_flag <= 1'h0;
        end
    end

    // a change in this cycle is passed on at once, not after the flag
    assign irq_pending = cmp_irq_flag | change;
    assign irq_gate    = cmp_irq_enable & global_irq_enable_instr;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_req <= 1'h0;
        end else begin
            irq_req <= irq_pending & irq_gate;
        end
    end

    assign low_power = sleep_mode | idle_mode;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wake_req <= 1'h0;
        end else begin
            wake_req <= change & cmp_irq_enable & low_power;
        end
    end

    // *****************************************************
    // pin routing
    // *****************************************************
    // pin four is free for other uses once the ladder feeds the inverting input
    assign pin4_cmp_req = int_ref_n_q & cmp_enable;
    assign pin3_cmp_req = cmp_enable;
    assign route_to_pin = (route_q == cmp_pkg::ROUTE_TO_PIN);
    assign pin5_cmp_req = route_to_pin;

    pin_arbiter u_pin4 (
        .req_special (ext_reference_in),
        .req_cmp     (pin4_cmp_req),
        .req_adc     (adc_channel_four),
        .fn          (fn4)
    );

    pin_arbiter u_pin3 (
        .req_special (1'h0),
        .req_cmp     (pin3_cmp_req),
        .req_adc     (adc_channel_three),
        .fn          (fn3)
    );

    pin_arbiter u_pin5 (
        .req_special (timer_ext_clock_in),
        .req_cmp     (pin5_cmp_req),
        .req_adc     (adc_channel_five),
        .fn          (fn5)
    );

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pin3_fn <= cmp_pkg::FN_PORT;
        end else begin
            pin3_fn <= fn3;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pin4_fn <= cmp_pkg::FN_PORT;
        end else begin
            pin4_fn <= fn4;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pin5_fn <= cmp_pkg::FN_PORT;
        end else begin
            pin5_fn <= fn5;
        end
    end

    // *****************************************************
    // comparator output pin
    // *****************************************************
    // timer clock request takes the pin away even with route set
    assign cmp_on_pin5 = (fn5 == cmp_pkg::FN_CMP);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cmp_output_pin <= 1'h0;
        end else begin
            cmp_output_pin <= cmp_on_pin5 & sync2_q;
        end
    end

    // driver enabled only while the pin carries the result
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cmp_output_oe_n <= 1'h1;
        end else begin
            cmp_output_oe_n <= ~cmp_on_pin5;
        end
    end
endmodule : comparator_control

// ### cmp_pkg.sv
// constants shared by the comparator control block
package cmp_pkg;
    // *****************************************************
    // control register field positions
    // *****************************************************
    localparam int           INT_REF_SEL_POS    = 7;
    localparam int           RATIO_MSB_POS      = 6;
    localparam int           RATIO_LSB_POS      = 3;
    localparam int           RESULT_POS         = 2;
    localparam int           ROUTE_HI_POS       = 1;
    localparam int           ROUTE_LO_POS       = 0;
    localparam int           IRQ_BIT_POS        = 7;
    localparam int           RATIO_W            = 4;
    // *****************************************************
    // reset values and encodings
    // *****************************************************
    localparam logic [3:0]   RATIO_RESET        = 4'hF;
    localparam logic [1:0]   ROUTE_RESET        = 2'h0;
    localparam logic [1:0]   ROUTE_TO_PIN       = 2'h2;
    localparam logic         INT_REF_SEL_RESET  = 1'h1;
    // *****************************************************
    // shared pin functions
    // *****************************************************
    typedef enum logic [1:0] {
        FN_PORT   = 2'h0,
        FN_ADC    = 2'h1,
        FN_CMP    = 2'h3,
        FN_SPECIAL = 2'h2
    } pin_fn_t;
endpackage : cmp_pkg

// ### pin_arbiter.sv
// fixed priority function arbiter for one shared pin
`timescale 1ns/1ps
module pin_arbiter (
    // requests, highest priority first
    input  wire logic           req_special,
    input  wire logic           req_cmp,
    input  wire logic           req_adc,
    // granted function
    output cmp_pkg::pin_fn_t    fn
);
    always_comb begin
        if (req_special) begin
            fn = cmp_pkg::FN_SPECIAL;
        end else if (req_cmp) begin
            fn = cmp_pkg::FN_CMP;
        end else if (req_adc) begin
            fn = cmp_pkg::FN_ADC;
        end else begin
            fn = cmp_pkg::FN_PORT;
        end
    end
endmodule : pin_arbiter

// ### comparator_control_checker.sv
// assertions on the comparator control ports
`timescale 1ns/1ps
module comparator_control_checker (
    // watched ports
    input wire logic             sys_clk, srst, irq_flag_clr, sleep_mode, idle_mode,
    input wire logic             ext_reference_in, adc_channel_three, timer_ext_clock_in, cmp_enable,
    input wire logic             global_irq_enable_instr, internal_ref_select_n, inv_from_ladder,
    input wire logic             cmp_result_bit, cmp_irq_enable, cmp_irq_flag, irq_req, wake_req,
    input wire cmp_pkg::pin_fn_t pin3_fn, pin4_fn, pin5_fn
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    property p_ladder; inv_from_ladder == !internal_ref_select_n; endproperty
    a_ladder: assert property (p_ladder) else $error("ladder select wrong");
    property p_pin4; $past(ext_reference_in) |-> pin4_fn == cmp_pkg::FN_SPECIAL; endproperty
    a_pin4: assert property (p_pin4) else $error("pin four priority wrong");
    property p_pin3; $past(cmp_enable) |-> pin3_fn == cmp_pkg::FN_CMP; endproperty
    a_pin3: assert property (p_pin3) else $error("pin three priority wrong");
    property p_pin3a; $past(adc_channel_three && !cmp_enable) |-> pin3_fn == cmp_pkg::FN_ADC; endproperty
    a_pin3a: assert property (p_pin3a) else $error("pin three adc grant wrong");
    property p_pin5; $past(timer_ext_clock_in) |-> pin5_fn == cmp_pkg::FN_SPECIAL; endproperty
    a_pin5: assert property (p_pin5) else $error("pin five priority wrong");
    property p_gate; irq_req |-> $past(cmp_irq_enable && global_irq_enable_instr); endproperty
    a_gate: assert property (p_gate) else $error("request without enables");
    property p_set; $changed(cmp_result_bit) |-> cmp_irq_flag; endproperty
    a_set: assert property (p_set) else $error("flag missed a change");
    property p_hold; cmp_irq_flag && !irq_flag_clr |=> cmp_irq_flag; endproperty
    a_hold: assert property (p_hold) else $error("flag cleared by itself");
    property p_wake; wake_req |-> cmp_irq_flag && $past(sleep_mode || idle_mode); endproperty
    a_wake: assert property (p_wake) else $error("wake outside low power");
endmodule : comparator_control_checker

// ### cmp_analog_model.sv
// analog comparator front end seen by the block
`timescale 1ns/1ps
module cmp_analog_model #(parameter int VDD_MV = 5000) (
    // analog levels in millivolts
    input var int          vin_plus_mv,
    input var int          vin_minus_mv,
    // ladder control
    input wire logic       inv_from_ladder,
    input wire logic [3:0] ref_ratio_code,
    // raw decision
    output logic           cmp_raw
);
    int vref_mv;
    assign vref_mv = inv_from_ladder ? VDD_MV * ref_ratio_code / 15 : vin_minus_mv;
    assign cmp_raw = vin_plus_mv > vref_mv;
endmodule : cmp_analog_model

// ### comparator_control_test.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
module comparator_control_test;
    logic sys_clk, srst, ctrl_we, irq_enable_we, irq_enable_wdata, irq_flag_clr, global_irq_enable_instr;
    logic sleep_mode, idle_mode, ext_reference_in, adc_channel_three, adc_channel_four, adc_channel_five;
    logic timer_ext_clock_in, cmp_enable, cmp_raw, internal_ref_select_n, inv_from_ladder, cmp_result_bit;
    logic cmp_irq_enable, cmp_irq_flag, irq_req, wake_req, cmp_output_pin, cmp_output_oe_n, seen;
    logic [7:0] ctrl_wdata, cmp_control_reg;
    logic [3:0] ref_ratio_code;
    cmp_pkg::pin_fn_t pin3_fn, pin4_fn, pin5_fn;
    int n_errors, n_tests, cycles, vin_mv;
    comparator_control uut (.*);
    cmp_analog_model model (.vin_plus_mv(vin_mv), .vin_minus_mv(1000), .inv_from_ladder, .ref_ratio_code,
        .cmp_raw);
    initial begin sys_clk = 0; forever #20 sys_clk = ~sys_clk; end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin n_errors++; print_verdict(); end
    end
    task automatic print_verdict();
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic wt(int n); repeat (n) @(negedge sys_clk); endtask : wt
    task automatic wr_ctrl(logic [7:0] d);
        ctrl_we = 1; ctrl_wdata = d; wt(1); ctrl_we = 0; wt(6);
    endtask : wr_ctrl
    task automatic t_reset();
        `CHECK(cmp_control_reg, 8'hF8)
        `CHECK({cmp_irq_flag, cmp_irq_enable, internal_ref_select_n, inv_from_ladder}, 4'h2)
    endtask : t_reset
    task automatic t_ladder();
        for (int n = 0; n < 16; n++) begin
            wr_ctrl({1'b0, n[3:0], 3'h0});
            `CHECK({inv_from_ladder, ref_ratio_code}, {1'b1, n[3:0]})
            // software reads the direction here
            `CHECK({cmp_result_bit, cmp_control_reg[2]}, {2{1'(n < 8)}})
        end
        wr_ctrl(8'h80);
        `CHECK({internal_ref_select_n, cmp_result_bit}, 2'h3)
    endtask : t_ladder
    task automatic t_irq();
        irq_flag_clr = 1; irq_enable_we = 1; irq_enable_wdata = 1; global_irq_enable_instr = 1; wt(1);
        irq_flag_clr = 0; irq_enable_we = 0; wt(3);
        `CHECK({cmp_irq_enable, cmp_irq_flag, irq_req}, 3'h4)
        vin_mv = 500; wt(5);
        `CHECK({cmp_irq_flag, irq_req, cmp_result_bit}, 3'h6)
        global_irq_enable_instr = 0; wt(20);
        `CHECK({cmp_irq_flag, irq_req}, 2'h2)
        irq_flag_clr = 1; wt(1); irq_flag_clr = 0; global_irq_enable_instr = 1; wt(2);
        `CHECK({cmp_irq_flag, irq_req}, 2'h0)
    endtask : t_irq
    task automatic t_route();
        wr_ctrl(8'h82);
        `CHECK({cmp_output_oe_n, cmp_output_pin, pin5_fn}, {2'h0, cmp_pkg::FN_CMP})
        vin_mv = 2500; wt(5);
        `CHECK({cmp_output_oe_n, cmp_output_pin}, 2'h1)
        timer_ext_clock_in = 1; wt(2);
        `CHECK({cmp_output_oe_n, pin5_fn}, {1'b1, cmp_pkg::FN_SPECIAL})
        timer_ext_clock_in = 0; adc_channel_five = 1; wr_ctrl(8'h80);
        `CHECK({cmp_output_oe_n, pin5_fn}, {1'b1, cmp_pkg::FN_ADC})
    endtask : t_route
    task automatic t_pins();
        ext_reference_in = 1; adc_channel_three = 1; adc_channel_four = 1; wt(2);
        `CHECK({pin4_fn, pin3_fn}, {cmp_pkg::FN_SPECIAL, cmp_pkg::FN_CMP})
        ext_reference_in = 0; wt(2);
        `CHECK(pin4_fn, cmp_pkg::FN_CMP)
        cmp_enable = 0; wt(2);
        `CHECK({pin4_fn, pin3_fn}, {cmp_pkg::FN_ADC, cmp_pkg::FN_ADC})
        adc_channel_three = 0; adc_channel_four = 0; wt(2);
        `CHECK({pin4_fn, pin3_fn}, 4'h0)
        cmp_enable = 1; wt(5);
    endtask : t_pins
    task automatic t_sleep();
        for (int m = 0; m < 2; m++) begin
            sleep_mode = (m == 0); idle_mode = (m == 1); seen = 0;
            vin_mv = (vin_mv == 500) ? 2500 : 500;
            repeat (8) begin wt(1); seen |= wake_req; end
            `CHECK({seen, cmp_irq_flag}, 2'h3)
        end
        // comparator off before a sleep without wake-up
        cmp_enable = 0; wt(5);
    endtask : t_sleep
    initial begin
        {ctrl_we, irq_enable_we, irq_enable_wdata, irq_flag_clr, global_irq_enable_instr} = '0;
        {sleep_mode, idle_mode, ext_reference_in, adc_channel_three, adc_channel_four} = '0;
        {adc_channel_five, timer_ext_clock_in, cmp_enable} = '0;
        ctrl_wdata = 8'h00; vin_mv = 2500; srst = 1;
        wt(5); srst = 0; wt(1);
        t_reset(); cmp_enable = 1;
        t_ladder(); t_irq(); t_route(); t_pins(); t_sleep();
        print_verdict();
    end
endmodule : comparator_control_test
bind comparator_control comparator_control_checker chk (.sys_clk, .srst, .irq_flag_clr, .sleep_mode,
    .idle_mode, .ext_reference_in, .adc_channel_three, .timer_ext_clock_in, .cmp_enable,
    .global_irq_enable_instr, .internal_ref_select_n, .inv_from_ladder, .cmp_result_bit, .cmp_irq_enable,
    .cmp_irq_flag, .irq_req, .wake_req, .pin3_fn, .pin4_fn, .pin5_fn);
